// *** design/dep_bcd.sv ***
// Binary card location to two-digit BCD converter
`timescale 1ns/10ps
module dep_bcd
   import dep_pkg::*;
(
   input  wire logic [4:0] bin,
   output logic [1:0]      tens,
   output logic [3:0]      units
);
   ////////////////////////////////////////////////////////////////
   // Locations 0 to 21 fit in a two-bit tens digit
   always_comb begin
      if (bin >= 5'h14) begin
         tens = 2'h2;
         units = 4'(bin - 5'h14);
      end else if (bin >= 5'h0a) begin
         tens = 2'h1;
         units = 4'(bin - 5'h0a);
      end else begin
         tens = 2'h0;
         units = bin[3:0];
      end
   end
endmodule

// *** design/dep_chan_det.sv ***
// Channel card error detector: samples one channel per scan strobe
`timescale 1ns/10ps
module dep_chan_det
   import dep_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       enable,
   input  wire logic       clear,
   input  wire logic       strobe,
   input  wire logic       status,
   input  wire logic [3:0] addr,
   output logic            err,
   output logic [3:0]      chan
);
   dep_det_s q;         // Registered state
   dep_det_s d;         // Next state
   logic     capture;   // A faulty channel is caught this cycle

   ////////////////////////////////////////////////////////////////
   // Next state: one channel examined per strobe rising edge
   always_comb begin
      d = q;
      d.strobe = strobe;
      capture = enable && strobe && !q.strobe && status
                && (addr != 4'h0) && !q.err;
      // Reset or inhibit drops the latched error, a capture wins
      if (clear || !enable) begin
         d.err = 1'b0;
         d.chan = 4'h0;
      end
      if (capture) begin
         d.err = 1'b1;
         d.chan = addr;
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign err = q.err;
   assign chan = q.chan;

   // Faulty channel address is held on the next cycle
   property p_capture;
      @(posedge mclk) disable iff (rst)
      (enable && strobe && !q.strobe && status && addr != 4'h0 && !q.err)
      |=> (err && chan == $past(addr));
   endproperty
   a_capture: assert property (p_capture) else $error("channel not captured");
endmodule

// *** design/dep_pkg.sv ***
// Types shared by the diagnostic priority display modules
`include "dep_regs.svh"
package dep_pkg;
   // Selected group code sent to address muxes and lamp decoder
   typedef enum logic [2:0] {
      DEP_GRP_TXC, DEP_GRP_TXCH, DEP_GRP_RXC, DEP_GRP_RXCH,
      DEP_GRP_OOT, DEP_GRP_ST, DEP_GRP_TIM, DEP_GRP_NONE
   } dep_grp_e;
   // Channel card error detector state
   typedef struct packed {
      logic       strobe;
      logic       err;
      logic [3:0] chan;
   } dep_det_s;
   // Main block state
   typedef struct packed {
      logic [`DEP_SYNC_W-1:0] sync1;
      logic [`DEP_SYNC_W-1:0] sync2;
      logic [2:0]             ctrl;
      logic                   err_rst;
      logic [`DEP_EV_W-1:0]   stat;
      logic [`DEP_EV_W-1:0]   mask;
      dep_grp_e               sel;
      logic [4:0]             loc;
      logic                   inhibit;
      logic                   lamp_txtim;
      logic                   lamp_rxtim;
      logic                   lamp_txcard;
      logic                   lamp_rxcard;
      logic [1:0]             tens;
      logic [3:0]             units;
      logic                   irq;
      logic [`DEP_DATA_W-1:0] rd_data;
   } dep_state_s;
endpackage

// *** design/dep_regs.svh ***
// Register map, field positions, reset values and display locations
`ifndef DEP_REGS_SVH
`define DEP_REGS_SVH
// Register offsets on the plain register port
`define DEP_ADDR_W       2
`define DEP_DATA_W       8
`define DEP_OFF_CTRL     2'h0
`define DEP_OFF_STAT     2'h1
`define DEP_OFF_MASK     2'h2
`define DEP_OFF_SHOW     2'h3
// Control register fields
`define DEP_CTRL_FUNC_LO 0
`define DEP_CTRL_FUNC_HI 1
`define DEP_CTRL_STEST   2
`define DEP_CTRL_ERST    3
`define DEP_FUNC_BOTH    2'h0
`define DEP_FUNC_TXOFF   2'h1
`define DEP_FUNC_RXOFF   2'h2
`define DEP_CTRL_RST     3'h0
// Status and mask fields
`define DEP_EV_W         5
`define DEP_EV_TXTIM     0
`define DEP_EV_RXTIM     1
`define DEP_EV_TXCARD    2
`define DEP_EV_RXCARD    3
`define DEP_EV_STFAIL    4
`define DEP_STAT_RST     5'h00
`define DEP_MASK_RST     5'h00
// Condition count and synchroniser width
`define DEP_N_COND       21
`define DEP_SYNC_W       31
// Card locations shown per priority slot
`define DEP_LOC_NONE     5'h00
`define DEP_LOC_P02      5'h10
`define DEP_LOC_P03      5'h15
`define DEP_LOC_P04      5'h14
`define DEP_LOC_P05      5'h15
`define DEP_LOC_P06      5'h14
`define DEP_LOC_P07      5'h13
`define DEP_LOC_P10      5'h15
`define DEP_LOC_P11      5'h10
`define DEP_LOC_P12      5'h14
`define DEP_LOC_P13      5'h11
`define DEP_LOC_P14      5'h15
`define DEP_LOC_P15      5'h10
`define DEP_LOC_P16      5'h11
`define DEP_LOC_P17      5'h14
`define DEP_LOC_P18      5'h13
`define DEP_LOC_P20      5'h10
`define DEP_LOC_P21      5'h15
// Expected self-test display digits
`define DEP_ST_TENS      2'h2
`define DEP_ST_UNITS     4'h1
`endif

// *** design/dep_top.sv ***
// Diagnostic error priority and front panel display logic
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "dep_regs.svh"
module dep_top
   import dep_pkg::*;
(
   input  wire logic                   mclk,
   input  wire logic                   rst,
   input  wire logic [`DEP_ADDR_W-1:0] addr,
   input  wire logic [`DEP_DATA_W-1:0] wr_data,
   input  wire logic                   wr_stb,
   input  wire logic                   rd_stb,
   output logic [`DEP_DATA_W-1:0]      rd_data,
   input  wire logic [5:0]             tx_card_err,
   input  wire logic [8:0]             rx_card_err,
   input  wire logic                   tx_timing_lost,
   input  wire logic                   rx_timing_lost,
   input  wire logic                   tx_channel_status_serial,
   input  wire logic [3:0]             overhead_channel_addr,
   input  wire logic                   word24_scan_strobe,
   input  wire logic                   rx_channel_status_serial,
   input  wire logic [3:0]             rx_channel_addr,
   input  wire logic                   rx_scan_strobe,
   input  wire logic                   channel_out_of_tolerance,
   input  wire logic                   err_reset,
   output logic                        lamp_tx_timing,
   output logic                        lamp_rx_timing,
   output logic                        lamp_tx_card,
   output logic                        lamp_rx_card,
   output logic                        card_addr_inhibit,
   output logic                        tens_digit_hi,
   output logic                        tens_digit_lo,
   output logic [3:0]                  units_digit_bits,
   output logic [2:0]                  sel_code,
   output logic                        irq
);
   ////////////////////////////////////////////////////////////////
   // Declarations
   dep_state_s                q;          // Registered state
   dep_state_s                d;          // Next state
   logic [`DEP_SYNC_W-1:0]    raw;        // Pins before synchronising
   logic [5:0]                s_txc;      // Transmit common card errors
   logic [8:0]                s_rxc;      // Receive common card errors
   logic                      s_txlot;    // Transmit timing lost
   logic                      s_rxlot;    // Receive timing lost
   logic                      s_txser;    // Transmit channel status
   logic                      s_txstb;    // Transmit word-24 strobe
   logic [3:0]                s_txadr;    // Transmit channel address
   logic                      s_rxser;    // Receive channel status
   logic                      s_rxstb;    // Receive scan strobe
   logic [3:0]                s_rxadr;    // Receive channel address
   logic                      s_oot;      // Out-of-tolerance
   logic                      s_erst;     // Error reset pin
   logic                      tx_en;      // Transmit diagnostics on
   logic                      rx_en;      // Receive diagnostics on
   logic                      both_diag_enabled;
   logic                      transmit_side_diag_inhibit;
   logic                      receive_side_diag_inhibit;
   logic                      st_mode;    // Self-test mode
   logic                      tx_ch_err;  // Transmit channel error
   logic                      rx_ch_err;  // Receive channel error
   logic [3:0]                tx_ch;      // Faulty transmit channel
   logic [3:0]                rx_ch;      // Faulty receive channel
   logic [`DEP_N_COND-1:0]    cond;       // Enabled error conditions
   logic [4:0]                win;        // Winning slot, 0 is top
   logic                      any;        // Some condition active
   logic [4:0]                win_loc;    // Location of the winner
   logic [1:0]                bcd_tens;   // Converted tens digit
   logic [3:0]                bcd_units;  // Converted units digit
   logic [`DEP_EV_W-1:0]      ev;         // Indicator rise events
   logic [`DEP_EV_W-1:0]      w1c;        // Status bits cleared

   ////////////////////////////////////////////////////////////////
   // Pin synchroniser packing
   assign raw = {err_reset, channel_out_of_tolerance, rx_channel_addr,
                 rx_scan_strobe, rx_channel_status_serial,
                 overhead_channel_addr, word24_scan_strobe,
                 tx_channel_status_serial, rx_timing_lost, tx_timing_lost,
                 rx_card_err, tx_card_err};
   // Only the second stage is read
   assign s_txc   = q.sync2[5:0];
   assign s_rxc   = q.sync2[14:6];
   assign s_txlot = q.sync2[15];
   assign s_rxlot = q.sync2[16];
   assign s_txser = q.sync2[17];
   assign s_txstb = q.sync2[18];
   assign s_txadr = q.sync2[22:19];
   assign s_rxser = q.sync2[23];
   assign s_rxstb = q.sync2[24];
   assign s_rxadr = q.sync2[28:25];
   assign s_oot   = q.sync2[29];
   assign s_erst  = q.sync2[30];

   ////////////////////////////////////////////////////////////////
   // Function selection decode, three positions
   assign transmit_side_diag_inhibit =
      (q.ctrl[`DEP_CTRL_FUNC_HI:`DEP_CTRL_FUNC_LO] == `DEP_FUNC_TXOFF);
   assign receive_side_diag_inhibit =
      (q.ctrl[`DEP_CTRL_FUNC_HI:`DEP_CTRL_FUNC_LO] == `DEP_FUNC_RXOFF);
   assign both_diag_enabled = !transmit_side_diag_inhibit
                              && !receive_side_diag_inhibit;
   assign tx_en = both_diag_enabled || receive_side_diag_inhibit;
   assign rx_en = both_diag_enabled || transmit_side_diag_inhibit;
   assign st_mode = q.ctrl[`DEP_CTRL_STEST];

   ////////////////////////////////////////////////////////////////
   // Channel card error detectors, one per direction
   dep_chan_det u_tx_det (
      .mclk   (mclk),
      .rst    (rst),
      .enable (tx_en),
      .clear  (q.err_rst),
      .strobe (s_txstb),
      .status (s_txser),
      .addr   (s_txadr),
      .err    (tx_ch_err),
      .chan   (tx_ch)
   );

   dep_chan_det u_rx_det (
      .mclk   (mclk),
      .rst    (rst),
      .enable (rx_en),
      .clear  (q.err_rst),
      .strobe (s_rxstb),
      .status (s_rxser),
      .addr   (s_rxadr),
      .err    (rx_ch_err),
      .chan   (rx_ch)
   );

   ////////////////////////////////////////////////////////////////
   // Condition vector in priority order, inhibited groups masked
   always_comb begin
      cond = '0;
      cond[0] = s_txlot && tx_en;
      cond[6:1] = s_txc & {6{tx_en}};
      cond[7] = tx_ch_err;
      cond[8] = s_rxlot && rx_en;
      cond[17:9] = s_rxc & {9{rx_en}};
      cond[18] = rx_ch_err;
      cond[19] = s_oot && tx_en;
      cond[20] = st_mode;
   end

   ////////////////////////////////////////////////////////////////
   // Fixed priority selection, lowest slot wins
   always_comb begin
      win = 5'h00;
      any = 1'b0;
      for (int i = `DEP_N_COND - 1; i >= 0; i--) begin
         if (cond[i]) begin
            win = 5'(i);
            any = 1'b1;
         end
      end
   end

   // Card location of the winning slot
   always_comb begin
      case (win)
         5'h01:   win_loc = `DEP_LOC_P02;
         5'h02:   win_loc = `DEP_LOC_P03;
         5'h03:   win_loc = `DEP_LOC_P04;
         5'h04:   win_loc = `DEP_LOC_P05;
         5'h05:   win_loc = `DEP_LOC_P06;
         5'h06:   win_loc = `DEP_LOC_P07;
         5'h07:   win_loc = {1'b0, tx_ch};
         5'h09:   win_loc = `DEP_LOC_P10;
         5'h0a:   win_loc = `DEP_LOC_P11;
         5'h0b:   win_loc = `DEP_LOC_P12;
         5'h0c:   win_loc = `DEP_LOC_P13;
         5'h0d:   win_loc = `DEP_LOC_P14;
         5'h0e:   win_loc = `DEP_LOC_P15;
         5'h0f:   win_loc = `DEP_LOC_P16;
         5'h10:   win_loc = `DEP_LOC_P17;
         5'h11:   win_loc = `DEP_LOC_P18;
         5'h12:   win_loc = {1'b0, rx_ch};
         5'h13:   win_loc = `DEP_LOC_P20;
         5'h14:   win_loc = `DEP_LOC_P21;
         default: win_loc = `DEP_LOC_NONE;  // Timing slots
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // Binary to BCD conversion of the next location; win_loc equals d.loc on
   // every path and keeps the converter out of the next-state loop
   dep_bcd u_bcd (
      .bin   (win_loc),
      .tens  (bcd_tens),
      .units (bcd_units)
   );

   ////////////////////////////////////////////////////////////////
   // Next state: sync, registers, selection, lamps, interrupt
   always_comb begin
      d = q;
      // Two-stage pin synchroniser
      d.sync1 = raw;
      d.sync2 = q.sync1;
      // Control write, a written error reset is a one-cycle pulse, the pin reset follows the synchronised pin level
      d.err_rst = s_erst;
      w1c = '0;
      if (wr_stb) begin
         case (addr)
            `DEP_OFF_CTRL: begin
               d.ctrl = wr_data[2:0];
               d.err_rst = s_erst || wr_data[`DEP_CTRL_ERST];
            end
            `DEP_OFF_STAT: w1c = wr_data[`DEP_EV_W-1:0];
            `DEP_OFF_MASK: d.mask = wr_data[`DEP_EV_W-1:0];
            default: ;   // Display register is read only
         endcase
      end
      // Group select code and lamp decode
      d.sel = DEP_GRP_NONE;
      d.loc = `DEP_LOC_NONE;
      d.inhibit = 1'b0;
      d.lamp_txtim = 1'b0;
      d.lamp_rxtim = 1'b0;
      d.lamp_txcard = 1'b0;
      d.lamp_rxcard = 1'b0;
      if (!any) begin
         d.sel = DEP_GRP_NONE;
      end else if (win == 5'h00 || win == 5'h08) begin
         d.sel = DEP_GRP_TIM;
         d.inhibit = 1'b1;
         d.lamp_txtim = (win == 5'h00);
         d.lamp_rxtim = (win == 5'h08);
      end else begin
         d.loc = win_loc;
         if (win <= 5'h06) begin
            d.sel = DEP_GRP_TXC;
         end else if (win == 5'h07) begin
            d.sel = DEP_GRP_TXCH;
         end else if (win <= 5'h11) begin
            d.sel = DEP_GRP_RXC;
         end else if (win == 5'h12) begin
            d.sel = DEP_GRP_RXCH;
         end else if (win == 5'h13) begin
            d.sel = DEP_GRP_OOT;
         end else begin
            d.sel = DEP_GRP_ST;
         end
         d.lamp_txcard = (win <= 5'h07) || (win >= 5'h13);
         d.lamp_rxcard = (win >= 5'h09) && (win <= 5'h12);
      end
      d.tens = bcd_tens;
      d.units = bcd_units;
      // Indicator rises and secondary self-test check
      ev = '0;
      ev[`DEP_EV_TXTIM] = d.lamp_txtim && !q.lamp_txtim;
      ev[`DEP_EV_RXTIM] = d.lamp_rxtim && !q.lamp_rxtim;
      ev[`DEP_EV_TXCARD] = d.lamp_txcard && !q.lamp_txcard;
      ev[`DEP_EV_RXCARD] = d.lamp_rxcard && !q.lamp_rxcard;
      ev[`DEP_EV_STFAIL] = st_mode && (q.sel == DEP_GRP_ST)
                           && ({q.tens, q.units}
                               != {`DEP_ST_TENS, `DEP_ST_UNITS});
      // Sticky status, a new event wins over the clear
      d.stat = (q.stat & ~w1c) | ev;
      d.irq = |(d.stat & d.mask);
      // Read data valid only in the cycle after the strobe
      d.rd_data = '0;
      if (rd_stb) begin
         case (addr)
            `DEP_OFF_CTRL: d.rd_data = {5'h00, q.ctrl};
            `DEP_OFF_STAT: d.rd_data = {3'h0, q.stat};
            `DEP_OFF_MASK: d.rd_data = {3'h0, q.mask};
            default:       d.rd_data = {q.sel, q.loc};
         endcase
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      if (rst) begin
         q <= '0;
         q.ctrl <= `DEP_CTRL_RST;
         q.stat <= `DEP_STAT_RST;
         q.mask <= `DEP_MASK_RST;
         q.sel <= DEP_GRP_NONE;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Outputs straight from the state register
   assign rd_data = q.rd_data;
   assign lamp_tx_timing = q.lamp_txtim;
   assign lamp_rx_timing = q.lamp_rxtim;
   assign lamp_tx_card = q.lamp_txcard;
   assign lamp_rx_card = q.lamp_rxcard;
   assign card_addr_inhibit = q.inhibit;
   assign tens_digit_hi = q.tens[1];
   assign tens_digit_lo = q.tens[0];
   assign units_digit_bits = q.units;
   assign sel_code = q.sel;
   assign irq = q.irq;

   ////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   // Transmit timing loss beats all and shows no location
   property p_txtim;
      cond[0] |=> (lamp_tx_timing && card_addr_inhibit && q.loc == 5'h00
                   && !lamp_tx_card && !lamp_rx_card);
   endproperty
   a_txtim: assert property (p_txtim) else $error("tx timing not shown");

   // Inhibited transmit group lights no transmit lamp outside self-test mode
   property p_txoff;
      (transmit_side_diag_inhibit && !st_mode)[*2] |=>
         (!lamp_tx_timing && !lamp_tx_card);
   endproperty
   a_txoff: assert property (p_txoff) else $error("inhibited tx shown");

   // Receive timing loss alone above it
   property p_rxtim;
      (cond[8] && cond[7:0] == 8'h00) |=>
         (lamp_rx_timing && card_addr_inhibit && sel_code == DEP_GRP_TIM);
   endproperty
   a_rxtim: assert property (p_rxtim) else $error("rx timing wrong");

   // First receive card condition shows location 21
   property p_rxc;
      (cond[9] && cond[8:0] == 9'h000) |=>
         (lamp_rx_card && q.loc == 5'h15);
   endproperty
   a_rxc: assert property (p_rxc) else $error("rx card location wrong");

   // Transmit channel error shows its channel number
   property p_txch;
      (cond[7] && cond[6:0] == 7'h00) |=>
         (q.loc == {1'b0, $past(tx_ch)} && q.loc != 5'h00 && lamp_tx_card);
   endproperty
   a_txch: assert property (p_txch) else $error("channel number wrong");

   // Out-of-tolerance alone shows 16 on the transmit lamp
   property p_oot;
      (cond == 21'h08_0000) |=> (q.loc == 5'h10 && lamp_tx_card);
   endproperty
   a_oot: assert property (p_oot) else $error("oot location wrong");

   // Self-test alone shows 21 as digits 2 and 1
   property p_st;
      (cond == 21'h10_0000) |=> (tens_digit_hi && !tens_digit_lo
                                 && units_digit_bits == 4'h1);
   endproperty
   a_st: assert property (p_st) else $error("self-test digits wrong");

   // Digits always encode the shown location
   property p_bcd;
      (q.tens * 10 + q.units) == q.loc;
   endproperty
   a_bcd: assert property (p_bcd) else $error("digits mismatch");

   // No condition means idle display
   property p_idle;
      (cond == 21'h00_0000) |=> (!lamp_tx_timing && !lamp_rx_timing
         && !lamp_tx_card && !lamp_rx_card && !card_addr_inhibit
         && q.loc == 5'h00 && sel_code == DEP_GRP_NONE);
   endproperty
   a_idle: assert property (p_idle) else $error("display not idle");

   // Interrupt tracks unmasked status
   property p_irq;
      irq == |(q.stat & q.mask);
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");
endmodule

// *** verification/dep_far.sv ***
// Far-side model: a channel card scan that reports one faulty channel
`timescale 1ns/10ps
module dep_far (
   input  wire logic       mclk,
   input  wire logic       go,
   input  wire logic [3:0] chan,
   output logic            strobe,
   output logic            status,
   output logic [3:0]      addr
);
   ////////////////////////////////////////////////////////////////
   // Idle: no strobe, lines show the inverse of the last value
   // One scan slot: status and address held over the strobe
   initial begin
      strobe = 1'b0;
      status = 1'b0;
      addr = 4'h0;
      forever begin
         @(posedge mclk);
         if (go) begin
            strobe <= 1'b1;
            status <= 1'b1;
            addr <= chan;
            repeat (2) @(posedge mclk);
            strobe <= 1'b0;
            status <= 1'b0;
            addr <= ~chan;
         end
      end
   end
endmodule

// *** verification/dep_top_tb.sv ***
// Self-checking bench for the diagnostic priority display
`timescale 1ns/10ps
`include "dep_regs.svh"
module dep_top_tb;
   logic        mclk = 0, rst = 1, wr_stb = 0, rd_stb = 0, rd_seen = 0;
   logic [1:0]  addr = 0;
   logic [7:0]  wr_data = 0, rd_data, re;
   logic [5:0]  txc = 0;
   logic [8:0]  rxc = 0;
   logic        ttl = 0, rtl = 0, oot = 0, erst = 0, tgo = 0, rgo = 0;
   logic [3:0]  ch = 0, tadr, radr, units;
   logic        tstb, tsts, rstb, rsts, l0, l1, l2, l3, inh, th, tl, irq;
   logic [2:0]  sel;
   logic [14:0] exp_q[$], got, e;
   logic [7:0]  rd_q[$];
   logic [31:0] r;
   int          n_errors = 0, n_checks = 0, i, c;
   int          txl[6] = '{16, 21, 20, 21, 20, 19};
   int          rxl[9] = '{21, 16, 20, 17, 21, 16, 17, 20, 19};
   event        smp;
   ////////////////////////////////////////////////////////////////
   dep_top uut (.mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rd_data(rd_data), .tx_card_err(txc), .rx_card_err(rxc),
      .tx_timing_lost(ttl), .rx_timing_lost(rtl), .tx_channel_status_serial(tsts),
      .overhead_channel_addr(tadr), .word24_scan_strobe(tstb),
      .rx_channel_status_serial(rsts), .rx_channel_addr(radr), .rx_scan_strobe(rstb),
      .channel_out_of_tolerance(oot), .err_reset(erst), .lamp_tx_timing(l0),
      .lamp_rx_timing(l1), .lamp_tx_card(l2), .lamp_rx_card(l3), .card_addr_inhibit(inh),
      .tens_digit_hi(th), .tens_digit_lo(tl), .units_digit_bits(units), .sel_code(sel),
      .irq(irq));
   dep_far tx_far (.mclk(mclk), .go(tgo), .chan(ch), .strobe(tstb), .status(tsts), .addr(tadr));
   dep_far rx_far (.mclk(mclk), .go(rgo), .chan(ch), .strobe(rstb), .status(rsts), .addr(radr));
   ////////////////////////////////////////////////////////////////
   // Expected display word: irq, lamps, inhibit, BCD digits, group
   function automatic logic [14:0] ev(input logic [3:0] l, input logic ih, input int lc,
                                      input logic [2:0] s, input logic q);
      return {q, l, ih, 2'(lc / 10), 4'(lc % 10), s};
   endfunction
   // Register write and read, one strobe cycle each
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk);
      wr_stb <= 1;
      addr <= a;
      wr_data <= d;
      @(posedge mclk);
      wr_stb <= 0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] x);
      @(posedge mclk);
      rd_stb <= 1;
      addr <= a;
      rd_q.push_back(x);
      @(posedge mclk);
      rd_stb <= 0;
   endtask
   // Note a display expectation once the pin latency has passed
   task automatic chk(input logic [14:0] x);
      repeat (8) @(posedge mclk);
      exp_q.push_back(x);
      @(negedge mclk);
      -> smp;
      @(posedge mclk);
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // Watchers compare the oldest note with what the outputs show
   always @(smp) begin
      got = {irq, l0, l1, l2, l3, inh, th, tl, units, sel};
      e = exp_q.pop_front();
      n_checks++;
      if (got !== e) begin
         n_errors++;
         $display("wrong value display expected %h seen %h", e, got);
      end
   end
   always @(posedge mclk) rd_seen <= rd_stb;
   always @(negedge mclk) begin
      if (rd_seen) begin
         re = rd_q.pop_front();
         n_checks++;
         if (rd_data !== re) begin
            n_errors++;
            $display("wrong value rd_data expected %h seen %h", re, rd_data);
         end
      end
   end
   initial forever #50 mclk = ~mclk;
   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      print_verdict;
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      r = $urandom(32'h7b3dfd31);
      repeat (10) @(posedge mclk);
      rst <= 0;
      chk(ev(4'h0, 0, 0, 3'h7, 0));
      wr(`DEP_OFF_MASK, 8'h04);
      for (i = 0; i < 6; i++) begin
         r = $urandom;
         txc <= 6'(r << (i + 1)) | 6'(1 << i);
         chk(ev(4'h2, 0, txl[i], 3'h0, 1));
      end
      ttl <= 1;
      chk(ev(4'h8, 1, 0, 3'h6, 1));
      rd(`DEP_OFF_STAT, 8'h05);
      wr(`DEP_OFF_STAT, 8'h1f);
      ttl <= 0;
      txc <= 0;
      for (i = 0; i < 9; i++) begin
         r = $urandom;
         rxc <= 9'(r << (i + 1)) | 9'(1 << i);
         chk(ev(4'h1, 0, rxl[i], 3'h2, 0));
      end
      rtl <= 1;
      chk(ev(4'h4, 1, 0, 3'h6, 0));
      rd(`DEP_OFF_STAT, 8'h0a);
      rtl <= 0;
      wr(`DEP_OFF_CTRL, 8'h01);
      txc <= 6'h01;
      chk(ev(4'h1, 0, 19, 3'h2, 0));
      wr(`DEP_OFF_CTRL, 8'h02);
      chk(ev(4'h2, 0, 16, 3'h0, 1));
      wr(`DEP_OFF_CTRL, 8'h00);
      txc <= 0;
      rxc <= 0;
      oot <= 1;
      chk(ev(4'h2, 0, 16, 3'h4, 1));
      oot <= 0;
      wr(`DEP_OFF_CTRL, 8'h04);
      chk(ev(4'h2, 0, 21, 3'h5, 1));
      wr(`DEP_OFF_CTRL, 8'h00);
      wr(`DEP_OFF_STAT, 8'h1f);
      c = 1 + $urandom % 15;
      ch <= 4'(c);
      tgo <= 1;
      @(posedge mclk);
      tgo <= 0;
      chk(ev(4'h2, 0, c, 3'h1, 1));
      erst <= 1;
      @(posedge mclk);
      erst <= 0;
      chk(ev(4'h0, 0, 0, 3'h7, 1));
      c = 1 + $urandom % 15;
      ch <= 4'(c);
      rgo <= 1;
      @(posedge mclk);
      rgo <= 0;
      chk(ev(4'h1, 0, c, 3'h3, 1));
      print_verdict;
   end
endmodule
